// File: seb_pkg.sv
// shared constants, opcodes, types and helper functions of the execute unit
package seb_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int unsigned INSTR_W  = 12;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned FADDR_W  = 5;
  localparam int unsigned BRANCH_W = 9;
  localparam int unsigned PAGE_W   = 2;
  localparam int unsigned PC_W     = 11;
  localparam int unsigned STAT_W   = 8;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned DEST_BIT = 5;
  localparam int unsigned OPC6_LSB = 6;
  localparam int unsigned OPC4_LSB = 8;
  localparam int unsigned OPC3_LSB = 9;
  localparam int unsigned PAGE_LSB = 5;

  // ****************************************
  // opcode values
  // ****************************************
  localparam logic [5:0] OPC_COMPL  = 6'h09;
  localparam logic [5:0] OPC_DEC    = 6'h03;
  localparam logic [5:0] OPC_DECSKP = 6'h0b;
  localparam logic [5:0] OPC_INC    = 6'h0a;
  localparam logic [5:0] OPC_INCSKP = 6'h0f;
  localparam logic [3:0] OPC_ORLIT  = 4'hd;
  localparam logic [2:0] OPC_BRANCH = 3'h5;

  // ****************************************
  // reset values and steps
  // ****************************************
  localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [PC_W-1:0]   PC_STEP   = 11'h001;
  localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;
  localparam logic [FADDR_W-1:0] FADDR_ZERO = 5'h00;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE                   = 3'h0,
    OP_COMPLEMENT_FILE        = 3'h1,
    OP_DECREMENT_FILE         = 3'h2,
    OP_DECREMENT_SKIP_ZERO    = 3'h3,
    OP_INCREMENT_FILE         = 3'h4,
    OP_INCREMENT_SKIP_ZERO    = 3'h5,
    OP_OR_LITERAL_ACCUM       = 3'h6,
    OP_UNCONDITIONAL_BRANCH   = 3'h7
  } seb_op_e;

  typedef enum logic [0:0] {
    ST_RUN   = 1'h0,
    ST_FLUSH = 1'h1
  } seb_state_e;

  typedef struct packed {
    seb_op_e              op;
    logic                 dest;
    logic [FADDR_W-1:0]   faddr;
    logic [DATA_W-1:0]    lit;
    logic [BRANCH_W-1:0]  target;
  } seb_dec_s;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    logic              zero;
    logic              skip;
    logic              setsZ;
  } seb_res_s;

  // ****************************************
  // op classes
  // ****************************************
  function automatic logic has_dest(seb_op_e op);
    return op inside {OP_COMPLEMENT_FILE, OP_DECREMENT_FILE, OP_DECREMENT_SKIP_ZERO,
                      OP_INCREMENT_FILE, OP_INCREMENT_SKIP_ZERO};
  endfunction

  function automatic logic sets_zero(seb_op_e op);
    return op inside {OP_COMPLEMENT_FILE, OP_DECREMENT_FILE, OP_INCREMENT_FILE,
                      OP_OR_LITERAL_ACCUM};
  endfunction

endpackage

// File: seb_decode.sv
// instruction word decoder into op class and operand fields
`timescale 1ns/10ps
module seb_decode (
  // instruction word
  input  wire logic [seb_pkg::INSTR_W-1:0] instr,
  // decoded fields
  output seb_pkg::seb_dec_s                dec
);

  // ****************************************
  // opcode decode
  // ****************************************
  function automatic seb_pkg::seb_op_e decode_op(logic [seb_pkg::INSTR_W-1:0] w);
    logic [5:0] opc6;
    opc6 = w[seb_pkg::INSTR_W-1:seb_pkg::OPC6_LSB];
    if (w[seb_pkg::INSTR_W-1:seb_pkg::OPC3_LSB] == seb_pkg::OPC_BRANCH) begin
      return seb_pkg::OP_UNCONDITIONAL_BRANCH;
    end
    if (w[seb_pkg::INSTR_W-1:seb_pkg::OPC4_LSB] == seb_pkg::OPC_ORLIT) begin
      return seb_pkg::OP_OR_LITERAL_ACCUM;
    end
    case (opc6)
      seb_pkg::OPC_COMPL:  return seb_pkg::OP_COMPLEMENT_FILE;
      seb_pkg::OPC_DEC:    return seb_pkg::OP_DECREMENT_FILE;
      seb_pkg::OPC_DECSKP: return seb_pkg::OP_DECREMENT_SKIP_ZERO;
      seb_pkg::OPC_INC:    return seb_pkg::OP_INCREMENT_FILE;
      seb_pkg::OPC_INCSKP: return seb_pkg::OP_INCREMENT_SKIP_ZERO;
      default:             return seb_pkg::OP_NONE;
    endcase
  endfunction

  assign dec.op     = decode_op(instr);
  assign dec.dest   = instr[seb_pkg::DEST_BIT];
  assign dec.faddr  = instr[seb_pkg::FADDR_W-1:0];
  assign dec.lit    = instr[seb_pkg::DATA_W-1:0];
  assign dec.target = instr[seb_pkg::BRANCH_W-1:0];

endmodule

// File: seb_alu.sv
// result, zero and skip computation for one decoded op
`timescale 1ns/10ps
module seb_alu (
  // operands
  input  seb_pkg::seb_op_e                op,
  input  wire logic [seb_pkg::DATA_W-1:0] operand,
  input  wire logic [seb_pkg::DATA_W-1:0] accum,
  input  wire logic [seb_pkg::DATA_W-1:0] lit,
  // result
  output seb_pkg::seb_res_s               res
);

  // ****************************************
  // datapath
  // ****************************************
  wire logic [seb_pkg::DATA_W-1:0] incVal;
  wire logic [seb_pkg::DATA_W-1:0] decVal;
  wire logic isInc;
  wire logic isDec;
  wire logic isSkip;

  // 8-bit sums wrap modulo 256
  assign incVal = operand + seb_pkg::DATA_ONE;
  assign decVal = operand - seb_pkg::DATA_ONE;
  assign isInc  = (op == seb_pkg::OP_INCREMENT_FILE) || (op == seb_pkg::OP_INCREMENT_SKIP_ZERO);
  assign isDec  = (op == seb_pkg::OP_DECREMENT_FILE) || (op == seb_pkg::OP_DECREMENT_SKIP_ZERO);
  assign isSkip = (op == seb_pkg::OP_INCREMENT_SKIP_ZERO) ||
                  (op == seb_pkg::OP_DECREMENT_SKIP_ZERO);

  assign res.value = isInc ? incVal :
                     isDec ? decVal :
                     (op == seb_pkg::OP_COMPLEMENT_FILE) ? ~operand :
                     (op == seb_pkg::OP_OR_LITERAL_ACCUM) ? (accum | lit) :
                     seb_pkg::DATA_ZERO;
  assign res.zero  = (res.value == seb_pkg::DATA_ZERO);
  assign res.skip  = isSkip && res.zero;
  assign res.setsZ = seb_pkg::sets_zero(op);

endmodule

// File: seb_exec.sv
// execute unit top: working register, branch, skip flush and file write-back
`timescale 1ns/10ps

module seb_exec #(
  parameter int unsigned PC_WIDTH = seb_pkg::PC_W
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // instruction stream
  input  wire logic [seb_pkg::INSTR_W-1:0]  instr,
  input  wire logic                         instrValid,
  output logic      [PC_WIDTH-1:0]          pcOut,
  output logic                              squashed,
  // file register read port
  output logic      [seb_pkg::FADDR_W-1:0]  fileRdAddr,
  input  wire logic [seb_pkg::DATA_W-1:0]   fileRdData,
  // file register write port
  output logic                              fileWrEn,
  output logic      [seb_pkg::FADDR_W-1:0]  fileWrAddr,
  output logic      [seb_pkg::DATA_W-1:0]   fileWrData,
  // status register
  input  wire logic [seb_pkg::STAT_W-1:0]   statusIn,
  output logic                              zWrEn,
  output logic                              zVal,
  // working register
  output logic      [seb_pkg::DATA_W-1:0]   wOut
);

  // ****************************************
  // elaboration check
  // ****************************************
  if (PC_WIDTH != seb_pkg::PAGE_W + seb_pkg::BRANCH_W) begin : g_pc_check
    $error("PC_WIDTH must equal page bits plus branch operand bits");
  end

  // ****************************************
  // declarations
  // ****************************************
  seb_pkg::seb_dec_s                 dec;
  seb_pkg::seb_res_s                 res;
  seb_pkg::seb_state_e               state_q;
  seb_pkg::seb_state_e               state_d;
  logic [PC_WIDTH-1:0]               pc_q;
  logic [PC_WIDTH-1:0]               pc_d;
  logic [seb_pkg::DATA_W-1:0]        wReg_q;
  logic [seb_pkg::DATA_W-1:0]        wReg_d;
  logic                              fileWrEn_q;
  logic [seb_pkg::FADDR_W-1:0]       fileWrAddr_q;
  logic [seb_pkg::DATA_W-1:0]        fileWrData_q;
  logic                              zWrEn_q;
  logic                              zVal_q;
  wire logic                         exec;
  wire logic                         fwdHit;
  wire logic [seb_pkg::DATA_W-1:0]   operand;
  wire logic                         toFile;
  wire logic                         toW;
  wire logic                         takeBranch;
  wire logic                         skipReq;
  wire logic [PC_WIDTH-1:0]          branchPc;
  wire logic [seb_pkg::PAGE_W-1:0]   page;

  // ****************************************
  // decode and datapath
  // ****************************************
  seb_decode u_decode (
    .instr (instr),
    .dec   (dec)
  );

  seb_alu u_alu (
    .op      (dec.op),
    .operand (operand),
    .accum   (wReg_q),
    .lit     (dec.lit),
    .res     (res)
  );

  // a slot arriving in flush state is consumed as a no-op
  assign exec     = instrValid && (state_q == seb_pkg::ST_RUN);
  assign squashed = instrValid && (state_q == seb_pkg::ST_FLUSH);

  // forward last write so back-to-back ops on one register see fresh data
  assign fwdHit     = fileWrEn_q && (fileWrAddr_q == dec.faddr);
  assign operand    = fwdHit ? fileWrData_q : fileRdData;
  assign fileRdAddr = dec.faddr;

  // destination routing
  assign toFile = exec && seb_pkg::has_dest(dec.op) && dec.dest;
  assign toW    = exec && ((seb_pkg::has_dest(dec.op) && !dec.dest) ||
                           (dec.op == seb_pkg::OP_OR_LITERAL_ACCUM));

  assign takeBranch = exec && (dec.op == seb_pkg::OP_UNCONDITIONAL_BRANCH);
  assign skipReq    = exec && res.skip;

  // page bits from status, operand into the low bits
  assign page     = statusIn[seb_pkg::PAGE_LSB +: seb_pkg::PAGE_W];
  assign branchPc = PC_WIDTH'({page, dec.target});

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    case (state_q)
      seb_pkg::ST_RUN: begin
        state_d = (takeBranch || skipReq) ? seb_pkg::ST_FLUSH : seb_pkg::ST_RUN;
      end
      seb_pkg::ST_FLUSH: begin
        state_d = instrValid ? seb_pkg::ST_RUN : seb_pkg::ST_FLUSH;
      end
      default: begin
        state_d = seb_pkg::ST_RUN;
      end
    endcase
  end

  assign pc_d   = takeBranch ? branchPc :
                  instrValid ? PC_WIDTH'(pc_q + PC_WIDTH'(seb_pkg::PC_STEP)) : pc_q;
  assign wReg_d = toW ? res.value : wReg_q;

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= seb_pkg::ST_RUN;
      pc_q    <= PC_WIDTH'(seb_pkg::PC_RESET);
      wReg_q  <= seb_pkg::DATA_ZERO;
    end else begin
      state_q <= state_d;
      pc_q    <= pc_d;
      wReg_q  <= wReg_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fileWrEn_q   <= 1'b0;
      fileWrAddr_q <= seb_pkg::FADDR_ZERO;
      fileWrData_q <= seb_pkg::DATA_ZERO;
    end else begin
      fileWrEn_q   <= toFile;
      fileWrAddr_q <= toFile ? dec.faddr : fileWrAddr_q;
      fileWrData_q <= toFile ? res.value : fileWrData_q;
    end
  end

  // only the zero flag is ever written; other status bits never touched
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zWrEn_q <= 1'b0;
      zVal_q  <= 1'b0;
    end else begin
      zWrEn_q <= exec && res.setsZ;
      zVal_q  <= (exec && res.setsZ) ? res.zero : zVal_q;
    end
  end

  assign pcOut      = pc_q;
  assign wOut       = wReg_q;
  assign fileWrEn   = fileWrEn_q;
  assign fileWrAddr = fileWrAddr_q;
  assign fileWrData = fileWrData_q;
  assign zWrEn      = zWrEn_q;
  assign zVal       = zVal_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  wire logic [seb_pkg::DATA_W-1:0] lastResult;
  assign lastResult = fileWrEn_q ? fileWrData_q : wReg_q;

  dest_w_route_a: assert property (
    exec && seb_pkg::has_dest(dec.op) && !dec.dest
    |=> wReg_q == $past(res.value) && !fileWrEn_q)
    else $error("dest 0 result not in working register");

  dest_f_route_a: assert property (
    exec && seb_pkg::has_dest(dec.op) && dec.dest
    |=> fileWrEn_q && fileWrData_q == $past(res.value)
        && fileWrAddr_q == $past(dec.faddr) && wReg_q == $past(wReg_q))
    else $error("dest 1 result not written back to file");

  complement_value_a: assert property (
    exec && dec.op == seb_pkg::OP_COMPLEMENT_FILE
    |=> zWrEn_q && lastResult == ~$past(operand))
    else $error("complement result wrong");

  decrement_value_a: assert property (
    exec && dec.op == seb_pkg::OP_DECREMENT_FILE
    |=> zWrEn_q && lastResult == $past(operand) - seb_pkg::DATA_ONE)
    else $error("decrement result wrong");

  dec_skip_a: assert property (
    exec && dec.op == seb_pkg::OP_DECREMENT_SKIP_ZERO
    |=> !zWrEn_q && lastResult == $past(operand) - seb_pkg::DATA_ONE
        && (state_q == seb_pkg::ST_FLUSH) == (lastResult == seb_pkg::DATA_ZERO))
    else $error("decrement-skip result or skip wrong");

  skip_flush_a: assert property (
    skipReq ##1 instrValid |-> squashed ##1 !fileWrEn_q && !zWrEn_q
                               && state_q == seb_pkg::ST_RUN)
    else $error("skipped slot not turned into a no-op");

  increment_value_a: assert property (
    exec && dec.op == seb_pkg::OP_INCREMENT_FILE
    |=> zWrEn_q && lastResult == $past(operand) + seb_pkg::DATA_ONE)
    else $error("increment result wrong");

  inc_skip_a: assert property (
    exec && dec.op == seb_pkg::OP_INCREMENT_SKIP_ZERO
    |=> !zWrEn_q && lastResult == $past(operand) + seb_pkg::DATA_ONE
        && (state_q == seb_pkg::ST_FLUSH) == (lastResult == seb_pkg::DATA_ZERO))
    else $error("increment-skip result or skip wrong");

  branch_target_a: assert property (
    takeBranch |=> pc_q == {$past(page), $past(dec.target)})
    else $error("branch target wrong");

  branch_two_cycle_a: assert property (
    takeBranch ##1 instrValid[*2] |-> exec && $past(squashed)
                                      && $past(state_q) == seb_pkg::ST_FLUSH)
    else $error("branch not two cycles");

  or_literal_a: assert property (
    exec && dec.op == seb_pkg::OP_OR_LITERAL_ACCUM
    |=> wReg_q == ($past(wReg_q) | $past(dec.lit)) && !fileWrEn_q && zWrEn_q)
    else $error("or-literal result wrong");

  zero_flag_a: assert property (
    zWrEn_q |-> zVal_q == (lastResult == seb_pkg::DATA_ZERO))
    else $error("zero flag does not match result");

  status_hold_a: assert property (
    (exec && !seb_pkg::sets_zero(dec.op)) || squashed |=> !zWrEn_q && $stable(zVal_q))
    else $error("status touched by op that must leave it");

  idle_quiet_a: assert property (
    !instrValid |=> !fileWrEn_q && !zWrEn_q && $stable(pc_q) && $stable(wReg_q)
                    && $stable(state_q))
    else $error("idle cycle changed state");

  squash_noop_a: assert property (
    squashed |=> !fileWrEn_q && !zWrEn_q && $stable(wReg_q)
                 && pc_q == PC_WIDTH'($past(pc_q) + PC_WIDTH'(seb_pkg::PC_STEP)))
    else $error("squashed slot had an effect");

  one_cycle_a: assert property (
    exec && !skipReq && !takeBranch
    |=> state_q == seb_pkg::ST_RUN
        && pc_q == PC_WIDTH'($past(pc_q) + PC_WIDTH'(seb_pkg::PC_STEP)))
    else $error("plain op did not take one cycle");

  page_bits_a: assert property (
    takeBranch
    |=> pc_q[PC_WIDTH-1 -: seb_pkg::PAGE_W]
          == $past(statusIn[seb_pkg::PAGE_LSB +: seb_pkg::PAGE_W])
        && pc_q[seb_pkg::BRANCH_W-1:0] == $past(instr[seb_pkg::BRANCH_W-1:0]))
    else $error("branch page or offset bits wrong");

  unknown_noop_a: assert property (
    exec && dec.op == seb_pkg::OP_NONE
    |=> !fileWrEn_q && !zWrEn_q && $stable(wReg_q) && state_q == seb_pkg::ST_RUN)
    else $error("unknown word had an effect");

  file_wr_src_a: assert property (
    fileWrEn_q |-> $past(exec && seb_pkg::has_dest(dec.op) && dec.dest))
    else $error("file write without a destination-1 op");

  zero_wr_src_a: assert property (
    zWrEn_q |-> $past(exec && seb_pkg::sets_zero(dec.op)))
    else $error("zero flag written by an op that must leave it");

  flush_wait_a: assert property (
    state_q == seb_pkg::ST_FLUSH && !instrValid |=> state_q == seb_pkg::ST_FLUSH)
    else $error("flush ended without a slot");

  wreg_hold_a: assert property (
    exec && !(seb_pkg::has_dest(dec.op) && !dec.dest)
         && dec.op != seb_pkg::OP_OR_LITERAL_ACCUM
    |=> $stable(wReg_q))
    else $error("working register changed by an op not aimed at it");

  skip_taken_c: cover property (skipReq ##1 squashed);
  branch_taken_c: cover property (takeBranch ##1 squashed ##1 exec);
  forward_hit_c: cover property (exec && fwdHit && seb_pkg::has_dest(dec.op));
  wrap_zero_c: cover property (exec && dec.op == seb_pkg::OP_INCREMENT_FILE && res.zero);
  flush_idle_c: cover property (state_q == seb_pkg::ST_FLUSH && !instrValid);

endmodule

// File: seb_exec_bench.sv
// self-checking testbench of the execute unit
`timescale 1ns/10ps
module seb_exec_bench;

  // ****************************************
  // signals
  // ****************************************
  logic                          clk;
  logic                          sys_rst;
  logic [seb_pkg::INSTR_W-1:0]   instr;
  logic                          instrValid;
  logic [seb_pkg::PC_W-1:0]      pcOut;
  logic                          squashed;
  logic [seb_pkg::FADDR_W-1:0]   fileRdAddr;
  logic [seb_pkg::DATA_W-1:0]    fileRdData;
  logic                          fileWrEn;
  logic [seb_pkg::FADDR_W-1:0]   fileWrAddr;
  logic [seb_pkg::DATA_W-1:0]    fileWrData;
  logic [seb_pkg::STAT_W-1:0]    statusIn;
  logic                          zWrEn;
  logic                          zVal;
  logic [seb_pkg::DATA_W-1:0]    wOut;
  logic [seb_pkg::DATA_W-1:0]    mem [32];
  logic [seb_pkg::PC_W-1:0]      expPc;
  logic [seb_pkg::DATA_W-1:0]    expW;
  int                            err_count;
  int                            compares;

  seb_exec DUT (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .instr      (instr),
    .instrValid (instrValid),
    .pcOut      (pcOut),
    .squashed   (squashed),
    .fileRdAddr (fileRdAddr),
    .fileRdData (fileRdData),
    .fileWrEn   (fileWrEn),
    .fileWrAddr (fileWrAddr),
    .fileWrData (fileWrData),
    .statusIn   (statusIn),
    .zWrEn      (zWrEn),
    .zVal       (zVal),
    .wOut       (wOut)
  );

  // ****************************************
  // clock and file register space
  // ****************************************
  always #50 clk = ~clk;

  assign fileRdData = mem[fileRdAddr];

  always @(posedge clk) begin
    if (fileWrEn) begin
      mem[fileWrAddr] <= fileWrData;
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // drives one slot, leaves it up; returns just after the edge that takes it
  task automatic slot(input logic [11:0] w, input logic sq);
    @(negedge clk);
    instr = w;
    instrValid = 1'b1;
    #1;
    chk("squashed", squashed, sq);
    chk("fileRdAddr", fileRdAddr, w[4:0]);
    if (!sq && w[11:9] == seb_pkg::OPC_BRANCH) begin
      expPc = {statusIn[6:5], w[8:0]};
    end else begin
      expPc = expPc + 11'h001;
    end
    @(posedge clk);
    #1;
    chk("pcOut", pcOut, expPc);
  endtask

  task automatic idle();
    @(negedge clk);
    instrValid = 1'b0;
    @(posedge clk);
    #1;
    chk("fileWrEn idle", fileWrEn, 1'b0);
    chk("zWrEn idle", zWrEn, 1'b0);
    chk("pcOut idle", pcOut, expPc);
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    chk("pcOut rst", pcOut, 11'h000);
    chk("wOut rst", wOut, 8'h00);
    chk("fileWrEn rst", fileWrEn, 1'b0);
    chk("zWrEn rst", zWrEn, 1'b0);
    $display("test reset done");
  endtask

  task automatic test_or_literal();
    logic [7:0] k [3];
    k = '{8'h00, 8'ha5, 8'h42};
    for (int i = 0; i < 3; i++) begin
      slot({seb_pkg::OPC_ORLIT, k[i]}, 1'b0);
      expW = expW | k[i];
      chk("wOut or", wOut, expW);
      chk("fileWrEn or", fileWrEn, 1'b0);
      chk("zWrEn or", zWrEn, 1'b1);
      chk("zVal or", zVal, expW == 8'h00);
    end
    idle();
    $display("test or_literal done");
  endtask

  task automatic test_file_ops();
    logic [5:0] opc [3];
    logic [7:0] vals [3];
    logic [4:0] fa [3];
    logic [7:0] res;
    opc = '{seb_pkg::OPC_COMPL, seb_pkg::OPC_DEC, seb_pkg::OPC_INC};
    vals = '{8'h00, 8'hff, 8'h5a};
    fa = '{5'h00, 5'h1f, 5'h0d};
    for (int i = 0; i < 3; i++) begin
      for (int d = 0; d < 2; d++) begin
        for (int j = 0; j < 3; j++) begin
          mem[fa[j]] = vals[j];
          res = (i == 0) ? ~vals[j] : (i == 1) ? vals[j] - 8'h01 : vals[j] + 8'h01;
          slot({opc[i], d[0], fa[j]}, 1'b0);
          chk("fileWrEn op", fileWrEn, d[0]);
          if (d == 1) begin
            chk("fileWrAddr", fileWrAddr, fa[j]);
            chk("fileWrData", fileWrData, res);
          end else begin
            expW = res;
          end
          chk("wOut op", wOut, expW);
          chk("zWrEn op", zWrEn, 1'b1);
          chk("zVal op", zVal, res == 8'h00);
          idle();
        end
      end
    end
    $display("test file_ops done");
  endtask

  task automatic skip_case(input logic [5:0] opc, input logic d, input logic [7:0] v);
    logic [7:0] res;
    logic       sk;
    res = (opc == seb_pkg::OPC_DECSKP) ? v - 8'h01 : v + 8'h01;
    sk = (res == 8'h00);
    mem[5'h03] = v;
    slot({opc, d, 5'h03}, 1'b0);
    chk("fileWrEn skip", fileWrEn, d);
    if (d) begin
      chk("fileWrData skip", fileWrData, res);
    end else begin
      expW = res;
    end
    chk("zWrEn skip", zWrEn, 1'b0);
    slot({seb_pkg::OPC_ORLIT, 8'h81}, sk);
    if (!sk) begin
      expW = expW | 8'h81;
    end
    chk("wOut after skip", wOut, expW);
    chk("zWrEn after skip", zWrEn, !sk);
    idle();
  endtask

  task automatic test_skips();
    skip_case(seb_pkg::OPC_DECSKP, 1'b1, 8'h01);
    skip_case(seb_pkg::OPC_DECSKP, 1'b0, 8'h05);
    skip_case(seb_pkg::OPC_INCSKP, 1'b0, 8'hff);
    skip_case(seb_pkg::OPC_INCSKP, 1'b1, 8'h7f);
    skip_case(seb_pkg::OPC_DECSKP, 1'b1, 8'h00);
    $display("test skips done");
  endtask

  task automatic test_branch();
    logic [8:0] k [4];
    k = '{9'h155, 9'h1ff, 9'h000, 9'h0aa};
    for (int p = 0; p < 4; p++) begin
      @(negedge clk);
      statusIn = 8'h9f | (p[7:0] << 5);
      slot({seb_pkg::OPC_BRANCH, k[p]}, 1'b0);
      chk("zWrEn branch", zWrEn, 1'b0);
      slot({seb_pkg::OPC_BRANCH, 9'h0f0}, 1'b1);
      slot({seb_pkg::OPC_ORLIT, 8'h00}, 1'b0);
      chk("zWrEn post", zWrEn, 1'b1);
      idle();
    end
    $display("test branch done");
  endtask

  task automatic test_forward();
    mem[5'h07] = 8'h10;
    slot(12'h000, 1'b0);
    chk("zWrEn none", zWrEn, 1'b0);
    chk("fileWrEn none", fileWrEn, 1'b0);
    chk("wOut none", wOut, expW);
    slot({seb_pkg::OPC_INC, 1'b1, 5'h07}, 1'b0);
    chk("fileWrData fwd1", fileWrData, 8'h11);
    slot({seb_pkg::OPC_INC, 1'b1, 5'h07}, 1'b0);
    chk("fileWrData fwd2", fileWrData, 8'h12);
    slot({seb_pkg::OPC_DEC, 1'b0, 5'h07}, 1'b0);
    expW = 8'h11;
    chk("wOut fwd", wOut, expW);
    chk("zVal fwd", zVal, 1'b0);
    idle();
    chk("mem fwd", mem[5'h07], 8'h12);
    slot({seb_pkg::OPC_BRANCH, 9'h033}, 1'b0);
    idle();
    idle();
    slot({seb_pkg::OPC_ORLIT, 8'h01}, 1'b1);
    slot({seb_pkg::OPC_ORLIT, 8'h00}, 1'b0);
    chk("wOut after wait", wOut, expW);
    idle();
    $display("test forward done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    instr = 12'h000;
    instrValid = 1'b0;
    statusIn = 8'h00;
    err_count = 0;
    compares = 0;
    expPc = 11'h000;
    expW = 8'h00;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'h00;
    end
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    test_reset();
    test_or_literal();
    test_file_ops();
    test_skips();
    test_forward();
    test_branch();
    end_sim();
  end

  initial begin
    #500000;
    err_count++;
    end_sim();
  end

endmodule
